// [rtl/driver_regs_pkg.sv]
// Shared constants for the gate driver global configuration and status block
package driver_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame layout
    localparam int FRAME_BITS = 40;
    localparam int DATA_BITS = 32;
    localparam int ADDR_BITS = 8;
    localparam int COUNT_BITS = 6;
    localparam logic [5:0] FRAME_COUNT = 6'h28;
    localparam logic [5:0] ADDR_LAST_COUNT = 6'h07;
    localparam int WRITE_FLAG_BIT = 7;
    localparam int REG_INDEX_BITS = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices, write access adds the write flag on top
    localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION = 7'h00;
    localparam logic [6:0] ADDR_GLOBAL_STATUS_FLAGS = 7'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields
    localparam int CFG_WIDTH = 8;
    localparam int CFG_DISABLE_BIT = 0;
    localparam int CFG_SINGLELINE_BIT = 1;
    localparam int CFG_FAULTDIRECT_BIT = 2;
    localparam int CFG_LOW_POWER_BIT = 6;
    localparam int CFG_TEST_MODE_BIT = 7;
    localparam logic [7:0] CFG_RESET_VALUE = 8'h02;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hC7;

    ////////////////////////////////////////////////////////////////////////////
    // Status fields
    localparam int ST_WIDTH = 15;
    localparam int ST_RESET_BIT = 0;
    localparam int ST_PREWARN_BIT = 1;
    localparam int ST_OVERTEMP_BIT = 2;
    localparam int ST_PUMP_BIT = 3;
    localparam int ST_SHORT_U_BIT = 4;
    localparam logic [14:0] ST_RESET_VALUE = 15'h0001;
    localparam logic [14:0] ST_USED_MASK = 15'h001F;
    localparam logic [14:0] ST_ENABLE_CYCLE_MASK = 15'h001C;
    localparam logic [14:0] ST_PIN_MASK = 15'h001C;

    ////////////////////////////////////////////////////////////////////////////
    // Pin groups
    localparam int PHASES = 3;
    localparam int PHASE_U = 0;
    localparam int SYNC_WIDTH = 10;

endpackage

// [rtl/pin_sync.sv]
// Two flip-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    // The first stage feeds only the second, never any logic
    always_comb begin
        st_d = st_q;
        st_d.stage1 = pin_in;
        st_d.stage2 = st_q.stage1;
    end

    // Both stages clear on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_sync_out = st_q.stage2;

endmodule

// [rtl/spi_frame.sv]
// Mode 3 serial slave that frames 40-bit register accesses on the system clock
`timescale 1ns/1ps
module spi_frame (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck_s,
    input wire logic cs_active_s,
    input wire logic sdi_s,
    input wire logic [31:0] rd_data,
    output logic [6:0] rd_index,
    output logic wr_pulse,
    output logic [6:0] wr_index,
    output logic [31:0] wr_data,
    output logic sdo,
    output logic sdo_oe
);

    typedef struct packed {
        logic sck_prev;
        logic cs_prev;
        logic [39:0] rx;
        logic [39:0] tx;
        logic [5:0] count;
        logic [7:0] last_addr;
        logic wr_pulse;
        logic [6:0] wr_index;
        logic [31:0] wr_data;
    } spi_s;

    spi_s st_q;
    spi_s st_d;

    logic sck_rise;
    logic sck_fall;
    logic cs_start;
    logic cs_end;

    // Edge detection on the synchronised bus lines
    assign sck_rise = sck_s & ~st_q.sck_prev;
    assign sck_fall = ~sck_s & st_q.sck_prev;
    assign cs_start = cs_active_s & ~st_q.cs_prev;
    assign cs_end = ~cs_active_s & st_q.cs_prev;

    // Register index of the byte being completed at the eighth rising edge
    assign rd_index = {st_q.rx[5:0], sdi_s};

    // Shift, reply and commit; short frames are dropped without effect
    always_comb begin
        st_d = st_q;
        st_d.sck_prev = sck_s;
        st_d.cs_prev = cs_active_s;
        st_d.wr_pulse = 1'b0;
        if (cs_start) begin
            st_d.count = '0;
            st_d.tx = {st_q.last_addr, {driver_regs_pkg::DATA_BITS{1'b0}}};
        end else if (cs_active_s && sck_rise) begin
            st_d.rx = {st_q.rx[38:0], sdi_s};
            if (st_q.count != driver_regs_pkg::FRAME_COUNT) begin
                st_d.count = st_q.count + 6'h01;
            end
            // Read data is fetched the moment the address byte is complete;
            // it sits one place below the top so the next falling edge shows bit 31
            if (st_q.count == driver_regs_pkg::ADDR_LAST_COUNT) begin
                st_d.tx = {st_q.tx[39], rd_data, {(driver_regs_pkg::ADDR_BITS - 1){1'h0}}};
            end
        end else if (cs_active_s && sck_fall && st_q.count != '0) begin
            // The first falling edge only opens the frame: the top bit is
            // already on the line, so shifting there would lose it
            st_d.tx = {st_q.tx[38:0], 1'b0};
        end else if (cs_end && st_q.count == driver_regs_pkg::FRAME_COUNT) begin
            st_d.last_addr = st_q.rx[39:32];
            if (st_q.rx[driver_regs_pkg::DATA_BITS + driver_regs_pkg::WRITE_FLAG_BIT]) begin
                st_d.wr_pulse = 1'b1;
                st_d.wr_index = st_q.rx[38:32];
                st_d.wr_data = st_q.rx[31:0];
            end
        end
    end

    // Mode 3 idles high, so the previous clock level resets high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.sck_prev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign wr_pulse = st_q.wr_pulse;
    assign wr_index = st_q.wr_index;
    assign wr_data = st_q.wr_data;
    assign sdo = st_q.tx[39];
    assign sdo_oe = cs_active_s;

endmodule

// [rtl/gate_driver_global_config_status.sv]
// Global configuration and status registers of a three phase gate driver
`timescale 1ns/1ps
module gate_driver_global_config_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic drv_en,
    output logic drv_en_test_oe,
    output logic [1:0] test_select,
    input wire logic [1:0] deadtime_clock_count,
    input wire logic [2:0] low_in,
    input wire logic [2:0] high_in,
    output logic [2:0] gate_low,
    output logic [2:0] gate_high,
    input wire logic ot_prewarn,
    input wire logic ot_shutdown,
    input wire logic pump_undervolt,
    input wire logic short_u_trigger,
    input wire logic overcurrent_action,
    input wire logic bridge_shutdown,
    output logic fault,
    output logic status_out,
    output logic low_power_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] config_bits;
        logic [14:0] status_bits;
        logic short_u_pending;
        logic drv_en_prev;
        logic fault;
        logic status_out;
        logic [2:0] gate_low;
        logic [2:0] gate_high;
    } core_s;

    core_s st_q;
    core_s st_d;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [9:0] pins_raw;
    logic [9:0] pins_s;
    logic sck_s;
    logic cs_active_s;
    logic sdi_s;
    logic drv_en_s;
    logic [2:0] low_s;
    logic [2:0] high_s;

    // Chip select and serial clock are inverted before syncing, so cleared
    // stages read as an idle bus and no false clock edge follows reset
    assign pins_raw = {high_in, low_in, drv_en, sdi, ~csn, ~sck};

    pin_sync #(
        .WIDTH(driver_regs_pkg::SYNC_WIDTH)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(pins_raw),
        .pin_sync_out(pins_s)
    );

    // Split the synchronised group back into named lines
    assign sck_s = ~pins_s[0]; // Back to the true clock level
    assign cs_active_s = pins_s[1];
    assign sdi_s = pins_s[2];
    assign drv_en_s = pins_s[3];
    assign low_s = pins_s[6:4];
    assign high_s = pins_s[9:7];

    ////////////////////////////////////////////////////////////////////////////
    // Serial access

    logic [6:0] rd_index;
    logic [31:0] rd_data;
    logic wr_pulse;
    logic [6:0] wr_index;
    logic [31:0] wr_data;

    spi_frame u_spi_frame (
        .clk(clk),
        .rst(rst),
        .sck_s(sck_s),
        .cs_active_s(cs_active_s),
        .sdi_s(sdi_s),
        .rd_data(rd_data),
        .rd_index(rd_index),
        .wr_pulse(wr_pulse),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .sdo(sdo),
        .sdo_oe(sdo_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Gate request pair {high, low} for one phase in either interface mode
    function automatic logic [1:0] phase_drive(
        input logic single_line,
        input logic lo,
        input logic hi
    );
        logic [1:0] req;
        req = {hi, lo};
        if (single_line) begin
            req = {hi & lo, ~hi & lo};
        end
        return req;
    endfunction

    // Register read mux; unmapped indices read as zero
    // Reads go through the same masks as writes, so unused bits always read zero
    function automatic logic [31:0] reg_read(
        input logic [6:0] index,
        input logic [7:0] cfg,
        input logic [14:0] stat
    );
        logic [31:0] value;
        value = '0;
        if (index == driver_regs_pkg::ADDR_GLOBAL_CONFIGURATION) begin
            value[7:0] = cfg & driver_regs_pkg::CFG_WRITE_MASK;
        end else if (index == driver_regs_pkg::ADDR_GLOBAL_STATUS_FLAGS) begin
            value[14:0] = stat & driver_regs_pkg::ST_USED_MASK;
        end
        return value;
    endfunction

    assign rd_data = reg_read(rd_index, st_q.config_bits, st_q.status_bits);

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls

    logic cfg_disable;
    logic cfg_single;
    logic cfg_faultdirect;
    logic cfg_test;
    logic wr_config;
    logic wr_status;
    logic enable_cycled;
    logic outputs_allowed;
    logic [1:0] drive_u;

    assign cfg_disable = st_q.config_bits[driver_regs_pkg::CFG_DISABLE_BIT];
    assign cfg_single = st_q.config_bits[driver_regs_pkg::CFG_SINGLELINE_BIT];
    assign cfg_faultdirect = st_q.config_bits[driver_regs_pkg::CFG_FAULTDIRECT_BIT];
    assign cfg_test = st_q.config_bits[driver_regs_pkg::CFG_TEST_MODE_BIT];

    // Writes only arrive with the write flag set in the address byte
    assign wr_config = wr_pulse && wr_index == driver_regs_pkg::ADDR_GLOBAL_CONFIGURATION;
    assign wr_status = wr_pulse && wr_index == driver_regs_pkg::ADDR_GLOBAL_STATUS_FLAGS;

    // Enable pin back on after having been off
    assign enable_cycled = drv_en_s & ~st_q.drv_en_prev;

    // Any global reason to hold every gate off; undervoltage and overtemperature
    // act on their live levels, not on the flags, so a flag clear never frees a gate
    assign outputs_allowed = drv_en_s & ~cfg_disable & ~pump_undervolt & ~ot_shutdown;

    // Phase U request, used to release a latched short
    assign drive_u = phase_drive(cfg_single, low_s[driver_regs_pkg::PHASE_U],
        high_s[driver_regs_pkg::PHASE_U]);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic [14:0] st_set;
    logic [14:0] st_clr;
    logic [1:0] req;

    always_comb begin
        st_d = st_q;
        st_set = '0;
        st_clr = '0;
        req = '0;
        st_d.drv_en_prev = drv_en_s;

        // Configuration write keeps only the implemented bits
        if (wr_config) begin
            st_d.config_bits = wr_data[7:0] & driver_regs_pkg::CFG_WRITE_MASK;
        end

        // Hardware events that latch flags
        st_set[driver_regs_pkg::ST_PREWARN_BIT] = ot_prewarn;
        st_set[driver_regs_pkg::ST_OVERTEMP_BIT] = ot_shutdown;
        st_set[driver_regs_pkg::ST_PUMP_BIT] = pump_undervolt;
        st_set[driver_regs_pkg::ST_SHORT_U_BIT] = short_u_trigger;

        // Write one to clear, zero leaves a flag alone
        if (wr_status) begin
            st_clr = wr_data[14:0] & driver_regs_pkg::ST_USED_MASK;
        end
        // Cycling the enable pin clears the shutdown class flags
        if (enable_cycled) begin
            st_clr = st_clr | driver_regs_pkg::ST_ENABLE_CYCLE_MASK;
        end
        // Reset indicator sticks while the enable pin is low
        if (!drv_en_s) begin
            st_clr[driver_regs_pkg::ST_RESET_BIT] = 1'b0;
        end
        // Shutdown flag sticks while the temperature is still over the limit
        if (ot_shutdown) begin
            st_clr[driver_regs_pkg::ST_OVERTEMP_BIT] = 1'b0;
        end
        // A set in the same cycle as a clear wins
        st_d.status_bits = ((st_q.status_bits & ~st_clr) | st_set)
            & driver_regs_pkg::ST_USED_MASK;

        // Short condition is released only by an off request on phase U or by the disable bit,
        // never by clearing its flag, so the flag clear is not looked at here
        if (short_u_trigger) begin
            st_d.short_u_pending = 1'b1;
        end else if (cfg_disable || drive_u == 2'b00) begin
            st_d.short_u_pending = 1'b0;
        end

        // Gate outputs, registered so they never glitch on input skew
        for (int i = 0; i < driver_regs_pkg::PHASES; i++) begin
            req = phase_drive(cfg_single, low_s[i], high_s[i]);
            if (!outputs_allowed) begin
                req = 2'b00;
            end
            // Only phase U has a short latch here; the other phases have no
            // short detection in this block, so they see no such hold
            if (i == driver_regs_pkg::PHASE_U && st_q.short_u_pending) begin
                req = 2'b00;
            end
            st_d.gate_high[i] = req[1];
            st_d.gate_low[i] = req[0];
        end

        // Fault output: persistent shutdown, or a pulse per shutdown action
        if (cfg_faultdirect) begin
            st_d.fault = overcurrent_action;
        end else begin
            st_d.fault = bridge_shutdown | ot_shutdown;
        end

        // Status pin follows the shutdown class flags
        st_d.status_out = |(st_d.status_bits & driver_regs_pkg::ST_PIN_MASK);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset loads the defaults and marks that a reset happened; the
    // reset flag is the only status bit that leaves reset set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.config_bits <= driver_regs_pkg::CFG_RESET_VALUE;
            st_q.status_bits <= driver_regs_pkg::ST_RESET_VALUE;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign gate_low = st_q.gate_low;
    assign gate_high = st_q.gate_high;
    assign fault = st_q.fault;
    assign status_out = st_q.status_out;
    assign low_power_mode = st_q.config_bits[driver_regs_pkg::CFG_LOW_POWER_BIT];

    // Test mode turns the enable pin around; the analog source is chosen
    // outside, this block only steers the select and the pin direction
    assign drv_en_test_oe = cfg_test;
    assign test_select = cfg_test ? deadtime_clock_count : 2'b00;

endmodule

// [verification/spi_host_model.sv]
// Host controller model that drives frames on the serial register bus
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    output logic sck,
    output logic csn,
    output logic sdi,
    input wire logic sdo
);
    ////////////////////////////////////////
    // Idle bus: clock parked high, device deselected
    initial begin
        sck = 1'b1;
        csn = 1'b1;
        sdi = 1'b0;
    end

    ////////////////////////////////////////
    // One 40-bit frame, MSB first, all changes on falling clk
    // Three clk per sck phase keeps sck at clk/6, the fastest rate allowed
    task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
        @(negedge clk);
        csn = 1'b0;
        repeat (3) @(negedge clk);
        for (int i = 39; i >= 0; i--) begin
            sck = 1'b0;
            sdi = tx[i];
            repeat (3) @(negedge clk);
            sck = 1'b1;
            rx[i] = sdo;
            repeat (3) @(negedge clk);
        end
        csn = 1'b1;
        // Released data line must not keep looking valid
        sdi = ~sdi;
        repeat (4) @(negedge clk);
    endtask
endmodule

// [verification/gate_driver_checker.sv]
// Port assertions for the gate driver register block
`timescale 1ns/1ps
module gate_driver_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic csn,
    input wire logic sdo_oe,
    input wire logic drv_en_test_oe,
    input wire logic [1:0] test_select,
    input wire logic [1:0] deadtime_clock_count,
    input wire logic [2:0] gate_low,
    input wire logic [2:0] gate_high,
    input wire logic ot_shutdown,
    input wire logic pump_undervolt,
    input wire logic short_u_trigger,
    input wire logic overcurrent_action,
    input wire logic bridge_shutdown,
    input wire logic fault,
    input wire logic status_out,
    input wire logic low_power_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    // Frame phases; sync delay hides the first two samples
    sequence sel_low;
        (!csn) [*3];
    endsequence
    sequence sel_busy;
        (!csn) [*8];
    endsequence
    // No fault cause for three cycles
    sequence calm;
        (!(bridge_shutdown || ot_shutdown || overcurrent_action)) [*3];
    endsequence

    ////////////////////////////////////////
    // Output relations with their stated latencies
    sdo_drive_a: assert property (sel_low |=> sdo_oe)
        else $error("sdo not enabled in frame");
    test_route_a: assert property (test_select == (drv_en_test_oe ? deadtime_clock_count : 2'h0))
        else $error("test select routing wrong");
    pump_gate_a: assert property (pump_undervolt |=> gate_low == 3'h0 && gate_high == 3'h0)
        else $error("gates on during undervoltage");
    ot_pin_a: assert property (ot_shutdown |=> status_out)
        else $error("status pin missed overtemperature");
    short_pin_a: assert property (short_u_trigger |=> status_out)
        else $error("status pin missed short");
    short_gate_a: assert property (short_u_trigger |-> ##2 (!gate_low[0] && !gate_high[0]))
        else $error("phase U gate on after short");
    fault_cause_a: assert property ($rose(fault) |-> $past(bridge_shutdown || ot_shutdown)
        || $past(overcurrent_action) || $past(overcurrent_action, 2))
        else $error("fault rose without cause");
    fault_quiet_a: assert property (calm |=> !fault)
        else $error("fault without cause");
    cfg_hold_a: assert property (sel_busy |=> $stable(low_power_mode) && $stable(drv_en_test_oe))
        else $error("configuration changed mid frame");
endmodule

bind gate_driver_global_config_status gate_driver_checker gate_driver_checker_i (
    .clk, .rst, .csn, .sdo_oe, .drv_en_test_oe, .test_select, .deadtime_clock_count,
    .gate_low, .gate_high, .ot_shutdown, .pump_undervolt, .short_u_trigger,
    .overcurrent_action, .bridge_shutdown, .fault, .status_out, .low_power_mode
);

// [verification/tb_top.sv]
// Self-checking bench for the gate driver register block
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, sck, csn, sdi, sdo, sdo_oe, drv_en, drv_en_test_oe, fault, f;
    logic ot_prewarn, ot_shutdown, pump_undervolt, short_u_trigger, overcurrent_action;
    logic bridge_shutdown, status_out, low_power_mode;
    logic [1:0] test_select, deadtime_clock_count;
    logic [2:0] low_in, high_in, gate_low, gate_high;
    logic [39:0] rx;
    int bad_count = 0;
    int comparisons = 0;

    gate_driver_global_config_status gate_driver_global_config_status_i (
        .clk, .rst, .sck, .csn, .sdi, .sdo, .sdo_oe, .drv_en, .drv_en_test_oe,
        .test_select, .deadtime_clock_count, .low_in, .high_in, .gate_low, .gate_high,
        .ot_prewarn, .ot_shutdown, .pump_undervolt, .short_u_trigger, .overcurrent_action,
        .bridge_shutdown, .fault, .status_out, .low_power_mode
    );
    spi_host_model spi_host_model_i (.clk, .sck, .csn, .sdi, .sdo);

    ////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////
    // Compares, one per kind of result
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t pins %b expected %b", $time, got, exp);
        end
    endtask
    // Register access; commit lands a few clk after the frame ends
    task automatic wr(input logic [6:0] idx, input logic [31:0] d);
        logic [39:0] r;
        spi_host_model_i.xfer({1'b1, idx, d}, r);
        repeat (8) @(negedge clk);
    endtask
    task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
        logic [39:0] r;
        spi_host_model_i.xfer({1'b0, idx, 32'h0}, r);
        chk_reg(r[31:0], exp);
    endtask
    // Pins pass two sync stages, so five clk covers every path
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic finish_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Watchdog sized well above the roughly 6900 clk of traffic
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end

    ////////////////////////////////////////
    // Test sequence
    initial begin
        rst = 1'b1;
        {drv_en, low_in, high_in, ot_prewarn, ot_shutdown, pump_undervolt} = '0;
        {short_u_trigger, overcurrent_action, bridge_shutdown} = '0;
        deadtime_clock_count = 2'h0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        spi_host_model_i.xfer({8'h00, 32'h0}, rx);
        chk_reg({24'h0, rx[39:32]}, 32'h0);
        chk_reg(rx[31:0], 32'h2);
        rd(7'h01, 32'h1);
        chk_pin({1'b0, low_power_mode, status_out}, 3'h0);
        done("reset");
        wr(7'h01, 32'h1);
        rd(7'h01, 32'h1);
        drv_en = 1'b1;
        settle();
        rd(7'h01, 32'h1);
        wr(7'h01, 32'h1);
        rd(7'h01, 32'h0);
        done("reset flag");
        wr(7'h00, 32'hFF);
        rd(7'h00, 32'hC7);
        chk_pin({1'b0, low_power_mode, drv_en_test_oe}, 3'h3);
        for (int i = 0; i < 4; i++) begin
            deadtime_clock_count = 2'(i);
            @(negedge clk);
            chk_pin({1'b0, test_select}, 3'(i));
        end
        wr(7'h00, 32'h42);
        chk_pin({drv_en_test_oe, test_select}, 3'h0);
        rd(7'h05, 32'h0);
        wr(7'h05, 32'h7F);
        rd(7'h00, 32'h42);
        done("config");
        wr(7'h00, 32'h40);
        low_in = 3'h5;
        high_in = 3'h2;
        settle();
        chk_pin(gate_low, 3'h5);
        chk_pin(gate_high, 3'h2);
        wr(7'h00, 32'h42);
        low_in = 3'h6;
        high_in = 3'h3;
        settle();
        chk_pin(gate_high, 3'h2);
        chk_pin(gate_low, 3'h4);
        wr(7'h00, 32'h43);
        chk_pin(gate_low | gate_high, 3'h0);
        done("gates");
        wr(7'h00, 32'h40);
        low_in = 3'h1;
        high_in = 3'h0;
        settle();
        chk_pin(gate_low, 3'h1);
        pulse(short_u_trigger);
        settle();
        chk_pin(gate_low, 3'h0);
        wr(7'h01, 32'h10);
        chk_pin(gate_low, 3'h0);
        low_in = 3'h0;
        settle();
        low_in = 3'h1;
        settle();
        chk_pin(gate_low, 3'h1);
        pulse(short_u_trigger);
        wr(7'h00, 32'h41);
        wr(7'h00, 32'h40);
        chk_pin(gate_low, 3'h1);
        done("short");
        low_in = 3'h2;
        settle();
        pulse(ot_prewarn);
        settle();
        chk_pin(gate_low, 3'h2);
        pulse(pump_undervolt);
        ot_shutdown = 1'b1;
        settle();
        chk_pin({2'h0, status_out}, 3'h1);
        wr(7'h01, 32'h0);
        rd(7'h01, 32'h1E);
        wr(7'h01, 32'h1F);
        rd(7'h01, 32'h4);
        ot_shutdown = 1'b0;
        settle();
        pulse(pump_undervolt);
        pulse(ot_prewarn);
        rd(7'h01, 32'hE);
        drv_en = 1'b0;
        settle();
        drv_en = 1'b1;
        settle();
        rd(7'h01, 32'h2);
        chk_pin({2'h0, status_out}, 3'h0);
        done("flags");
        bridge_shutdown = 1'b1;
        settle();
        chk_pin({2'h0, fault}, 3'h1);
        bridge_shutdown = 1'b0;
        settle();
        chk_pin({2'h0, fault}, 3'h0);
        wr(7'h00, 32'h44);
        bridge_shutdown = 1'b1;
        settle();
        chk_pin({2'h0, fault}, 3'h0);
        bridge_shutdown = 1'b0;
        pulse(overcurrent_action);
        f = fault;
        repeat (2) begin
            @(negedge clk);
            f = f | fault;
        end
        chk_pin({2'h0, f}, 3'h1);
        settle();
        chk_pin({2'h0, fault}, 3'h0);
        done("fault");
        finish_test();
    end
endmodule
